// ---- hdl/css_consts.svh ----
// Purpose: Constants of the configuration startup sequencer.
// Assumes: Register words are 32 bits on a classic Wishbone slave.
// Notes: Offsets are byte addresses of aligned words.
`ifndef CSS_CONSTS_SVH
`define CSS_CONSTS_SVH
`define CSS_OFF_CTRL 8'h00
`define CSS_OFF_PHASE 8'h04
`define CSS_OFF_STATUS 8'h08
`define CSS_OFF_CRCREF 8'h0c
`define CSS_OFF_DATA 8'h10
`define CSS_OFF_CMD 8'h14
`define CSS_SEL_DONE 4'h0
`define CSS_SEL_KEEP 4'h7
`define CSS_SEL_NOWAIT 4'h7
`define CSS_RST_PHASE 32'h00075664
`define CSS_RST_CTRL 32'h00000404
`define CSS_CRC_POLY 32'h04c11db7
`define CSS_CRC_INIT 32'hffffffff
`define CSS_LAST_PHASE 3'h7
`define CSS_CMD_HALT 2
`define CSS_CMD_HIGH 3
`endif

// ---- hdl/css_pkg.sv ----
// Purpose: Types of the configuration startup sequencer.
// Assumes: Constants come from css_consts.svh.
// Notes: Phase selectors are 4-bit codes, 0 meaning the sampled finish input.
package css_pkg;
  typedef enum logic [1:0] {CSS_LOAD, CSS_RUN, CSS_END} css_state_type;
  typedef enum logic [1:0] {CSS_CK_CFG, CSS_CK_USER, CSS_CK_SCAN} css_clksel_type;
  typedef struct packed {
    logic [3:0] lock_wait_phase;
    logic [3:0] tristate_release_phase;
    logic [3:0] write_enable_phase;
    logic [3:0] set_reset_release_phase;
    logic [3:0] finish_phase;
  } css_phase_type;
  typedef struct packed {
    logic global_set_reset;
    logic global_write_enable;
    logic global_tristate;
    logic global_high_hold;
  } css_glob_type;
endpackage

// ---- hdl/css_sequencer.sv ----
// Purpose: Post-configuration startup sequencer with CRC check and Wishbone registers.
// Assumes: Startup, user and scan clocks are slow inputs sampled by clk_sys.
// Notes: Phase selector codes 1 to 6 are phases, 0 is finish-high, 7 is keep or no wait.
`timescale 1ns/1ns
`include "css_consts.svh"

// What this block does
// - Finish output at phase one-six, default four.
// - Pipeline option stalls phases after finish until sampled finish is high.
// - Pipelined: wait finish pin high, then edge.
// - Sampled finish is pin or delayed copy.
// - Set-reset released at phase, finish, or kept.
// - Keep blocks destructive control during reconfiguration.
// - Write enable asserted at phase or finish.
// - Block memory access blocked until write phase.
// - Keep leaves write enable unchanged.
// - Tristate released at phase, default five.
// - CRC mismatch refuses configuration completion.
// - CRC disabled: constant word, no computation.
// - Live reconfig suppresses high hold, set-reset.
// - Halt plus high command resets clock manager.
// - Configuration clock rate selectable, default four.
// - Impedance match update policy selectable.
// - Active finish drive drives pin high.
// - Optional stall for clock manager lock.
// - Startup clock source selectable.
module css_sequencer
  import css_pkg::*;
(
  // System
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Startup clock sources and pins
  input wire logic cfg_clk_in,
  input wire logic user_clk_in,
  input wire logic scan_clk_in,
  input wire logic finish_pin_i,
  input wire logic clock_lock_i,
  // Finish pin and global controls
  output logic finish_pin_o,
  output logic finish_pin_oe_n,
  output css_glob_type glob_o,
  output logic block_memory_en_o,
  output logic clock_manager_rst_o,
  output logic [5:0] config_clock_rate_o,
  output logic [1:0] impedance_update_policy_o
);
  css_state_type state_r, state_nxt;
  css_phase_type phase_cfg_r;
  css_glob_type glob_r;
  logic [31:0] ctrl_r, crc_r, crcref_r;
  logic [2:0] phase_r;
  logic [1:0] fin_sync_r, uclk_sync_r, cclk_sync_r, sclk_sync_r, lock_sync_r;
  logic fin_dly_r, sclk_prev_r, crc_bad_r, fin_out_r, bmem_r, dcm_rst_r, ack_r, oe_n_r;
  logic [31:0] rdat_r;

  // Control bits: 0 pipeline, 2 crc enable, 3 live reconfig,
  // 4 halt-reset enable, 5 active drive, 7:6 clock select, 13:8 rate, 15:14 policy.
  wire finish_pipeline_option = ctrl_r[0];
  wire crc_enable = ctrl_r[2];
  wire live_partial_reconfig = ctrl_r[3];
  wire clock_manager_reset_on_halt = ctrl_r[4];
  wire active_finish_drive = ctrl_r[5];
  wire [1:0] startup_clock_select = ctrl_r[7:6];

  wire bus_req = wb_cyc_i && wb_stb_i && !ack_r;
  wire wr_req = bus_req && wb_we_i;
  wire wr_ctrl = wr_req && wb_adr_i == `CSS_OFF_CTRL;
  wire wr_phase = wr_req && wb_adr_i == `CSS_OFF_PHASE;
  wire wr_crcref = wr_req && wb_adr_i == `CSS_OFF_CRCREF;
  wire wr_data = wr_req && wb_adr_i == `CSS_OFF_DATA && state_r == CSS_LOAD;
  wire wr_cmd = wr_req && wb_adr_i == `CSS_OFF_CMD;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        res[i*8 +: 8] = new_v[i*8 +: 8];
    return res;
  endfunction

  function automatic logic [31:0] crc_step(input logic [31:0] crc, input logic [31:0] d);
    logic [31:0] c;
    c = crc;
    for (int i = 31; i >= 0; i--)
      c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? `CSS_CRC_POLY : 32'h0);
    return c;
  endfunction

  // Selector reached: phase code 1..6 met, or code 0 with finish input high.
  function automatic logic sel_reached(input logic [3:0] sel, input logic [2:0] ph,
                                       input logic fin_in);
    return (sel == `CSS_SEL_DONE) ? fin_in :
           (sel < `CSS_SEL_KEEP) && ({1'b0, ph} >= sel);
  endfunction

  // Startup clock select picks one synchronised source for edge detection.
  // clock source select
  wire sclk_now = (startup_clock_select == 2'(CSS_CK_USER)) ? uclk_sync_r[1] :
                  (startup_clock_select == 2'(CSS_CK_SCAN)) ? sclk_sync_r[1] :
                  cclk_sync_r[1];
  wire sclk_edge = sclk_now && !sclk_prev_r;

  wire sampled_finish_input = finish_pipeline_option ? fin_dly_r : fin_sync_r[1];

  wire lock_stall = phase_cfg_r.lock_wait_phase != `CSS_SEL_NOWAIT &&
                    {1'b0, phase_r} == phase_cfg_r.lock_wait_phase && !lock_sync_r[1];
  wire pipe_stall = finish_pipeline_option && fin_out_r && !sampled_finish_input;
  wire advance = state_r == CSS_RUN && sclk_edge && !lock_stall && !pipe_stall;

  wire fin_due = sel_reached(phase_cfg_r.finish_phase, phase_r, 1'b0);
  wire fin_out_nxt = fin_out_r || (state_r != CSS_LOAD && fin_due);
  wire gsr_rel = sel_reached(phase_cfg_r.set_reset_release_phase, phase_r,
                             sampled_finish_input);
  wire gwe_set = sel_reached(phase_cfg_r.write_enable_phase, phase_r, sampled_finish_input);
  wire gts_rel = sel_reached(phase_cfg_r.tristate_release_phase, phase_r,
                             sampled_finish_input);
  wire gsr_keep = phase_cfg_r.set_reset_release_phase == `CSS_SEL_KEEP;
  wire gwe_keep = phase_cfg_r.write_enable_phase == `CSS_SEL_KEEP;
  wire gts_keep = phase_cfg_r.tristate_release_phase == `CSS_SEL_KEEP;

  // refuse on mismatch; no CRC when disabled
  wire crc_ok = !crc_enable || crc_r == crcref_r;

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      CSS_LOAD:
        if (wr_cmd && wb_dat_i[0] && crc_ok)
          state_nxt = CSS_RUN;
      CSS_RUN:
        if (advance && phase_r == `CSS_LAST_PHASE)
          state_nxt = CSS_END;
      CSS_END:
        state_nxt = CSS_END;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      fin_sync_r <= 2'h0;
      uclk_sync_r <= 2'h0;
      cclk_sync_r <= 2'h0;
      sclk_sync_r <= 2'h0;
      lock_sync_r <= 2'h0;
      fin_dly_r <= 1'b0;
      sclk_prev_r <= 1'b0;
    end
    else
    begin
      fin_sync_r <= {fin_sync_r[0], finish_pin_i};
      uclk_sync_r <= {uclk_sync_r[0], user_clk_in};
      cclk_sync_r <= {cclk_sync_r[0], cfg_clk_in};
      sclk_sync_r <= {sclk_sync_r[0], scan_clk_in};
      lock_sync_r <= {lock_sync_r[0], clock_lock_i};
      // finish delayed by a startup edge
      if (sclk_edge)
        fin_dly_r <= fin_sync_r[1];
      sclk_prev_r <= sclk_now;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl_r <= `CSS_RST_CTRL;
      phase_cfg_r <= css_phase_type'(20'(`CSS_RST_PHASE));
      crcref_r <= 32'h0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_r <= merge_bytes(ctrl_r, wb_dat_i, wb_sel_i);
      // The whole selector word is taken at once, so no half-written selector acts.
      if (wr_phase)
        phase_cfg_r <= css_phase_type'(wb_dat_i[19:0]);
      if (wr_crcref)
        crcref_r <= merge_bytes(crcref_r, wb_dat_i, wb_sel_i);
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_r <= CSS_LOAD;
      phase_r <= 3'h0;
      crc_r <= `CSS_CRC_INIT;
      crc_bad_r <= 1'b0;
      fin_out_r <= 1'b0;
      oe_n_r <= 1'b1;
      glob_r <= '{global_set_reset: 1'b1, global_write_enable: 1'b0,
                  global_tristate: 1'b1, global_high_hold: 1'b1};
      bmem_r <= 1'b0;
      dcm_rst_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      if (advance && phase_r != `CSS_LAST_PHASE)
        phase_r <= phase_r + 3'h1;
      if (wr_data && crc_enable)
        crc_r <= crc_step(crc_r, wb_dat_i);
      if (wr_cmd && wb_dat_i[0] && state_r == CSS_LOAD)
        crc_bad_r <= !crc_ok;
      fin_out_r <= fin_out_nxt;
      oe_n_r <= !(fin_out_nxt && active_finish_drive);
      glob_r.global_high_hold <= live_partial_reconfig ? 1'b0 :
                                 (state_r == CSS_LOAD);
      if (live_partial_reconfig || (state_r != CSS_LOAD && gsr_rel && !gsr_keep))
        glob_r.global_set_reset <= 1'b0;
      if (state_r != CSS_LOAD && gwe_set && !gwe_keep)
        glob_r.global_write_enable <= 1'b1;
      if (state_r != CSS_LOAD && gts_rel && !gts_keep)
        glob_r.global_tristate <= 1'b0;
      if (state_r != CSS_LOAD && gwe_set && !gwe_keep)
        bmem_r <= 1'b1;
      dcm_rst_r <= wr_cmd && clock_manager_reset_on_halt &&
                   wb_dat_i[`CSS_CMD_HALT] && wb_dat_i[`CSS_CMD_HIGH];
    end
  end

  wire [31:0] status_w = {crc_r[15:0], 8'h0, crc_bad_r, fin_out_r, 1'b0,
                          2'(state_r), phase_r};
  wire [31:0] rsel_w = (wb_adr_i == `CSS_OFF_CTRL) ? ctrl_r :
                       (wb_adr_i == `CSS_OFF_PHASE) ? 32'(phase_cfg_r) :
                       (wb_adr_i == `CSS_OFF_STATUS) ? status_w :
                       (wb_adr_i == `CSS_OFF_CRCREF) ? crcref_r : 32'h0;

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ack_r <= 1'b0;
      rdat_r <= 32'h0;
    end
    else
    begin
      ack_r <= bus_req;
      rdat_r <= bus_req ? rsel_w : 32'h0;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
  assign finish_pin_o = fin_out_r;
  assign finish_pin_oe_n = oe_n_r;
  assign glob_o = glob_r;
  assign block_memory_en_o = bmem_r;
  assign clock_manager_rst_o = dcm_rst_r;
  assign config_clock_rate_o = ctrl_r[13:8];
  assign impedance_update_policy_o = ctrl_r[15:14];

  // a_fin_phase checks finish only after leaving load.
  a_fin_phase: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(fin_out_r) |-> $past(state_r) != CSS_LOAD)
    else $error("Finish rose during load.");
  a_phase_step: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $changed(phase_r) |-> phase_r == $past(phase_r) + 3'h1 && $past(sclk_edge))
    else $error("Phase moved without a single startup edge.");
  a_lock_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    lock_stall |=> $stable(phase_r))
    else $error("Phase advanced while waiting for lock.");
  a_crc_refuse: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wr_cmd && wb_dat_i[0] && state_r == CSS_LOAD && !crc_ok |=> state_r == CSS_LOAD)
    else $error("Start accepted with bad checksum.");
  a_crc_skip: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !crc_enable |=> $stable(crc_r))
    else $error("Checksum changed while disabled.");
  a_gwe_keep: assert property (@(posedge clk_sys) disable iff (sys_rst)
    gwe_keep |=> $stable(glob_r.global_write_enable))
    else $error("Write enable changed under keep.");
  a_bmem_gwe: assert property (@(posedge clk_sys) disable iff (sys_rst)
    bmem_r == glob_r.global_write_enable)
    else $error("Block memory enable differs from write enable.");
  a_live_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    live_partial_reconfig |=> !glob_r.global_high_hold && !glob_r.global_set_reset)
    else $error("Hold or set-reset during live reconfiguration.");
  a_halt_reset: assert property (@(posedge clk_sys) disable iff (sys_rst)
    clock_manager_rst_o |-> $past(wr_cmd) && $past(clock_manager_reset_on_halt))
    else $error("Clock manager reset without halt command.");
  c_run: cover property (@(posedge clk_sys) state_r == CSS_RUN);
  c_end: cover property (@(posedge clk_sys) state_r == CSS_END);
  c_refused: cover property (@(posedge clk_sys) crc_bad_r);
  c_lock: cover property (@(posedge clk_sys) lock_stall);
endmodule

// ---- verif/css_far_model.sv ----
// Purpose: Far-side model: startup clock source and the finish pin wire.
// Assumes: The finish pin has a pull-up and another device may hold it low.
// Notes: The startup clock stands still at low outside a run window.
`timescale 1ns/1ns
module css_far_model
(
  // Control from bench
  input wire logic run,
  input wire logic [1:0] sel,
  input wire logic hold_low,
  // Finish pin from block
  input wire logic finish_pin_o,
  input wire logic finish_pin_oe_n,
  // To block
  output logic cfg_clk_in,
  output logic user_clk_in,
  output logic scan_clk_in,
  output logic finish_pin_i
);
  logic sclk;
  // An odd offset keeps the startup clock edges clear of the system clock edges.
  initial
  begin
    sclk = 1'b0;
    #7;
    forever
    begin
      #160;
      sclk = run ? ~sclk : 1'b0;
    end
  end
  assign cfg_clk_in = sclk & (sel == 2'h0);
  assign user_clk_in = sclk & (sel == 2'h1);
  assign scan_clk_in = sclk & (sel == 2'h2);
  // A driven level wins, else the pull-up unless held low.
  assign finish_pin_i = !finish_pin_oe_n ? finish_pin_o : !hold_low;
endmodule

// ---- verif/css_sequencer_tb.sv ----
// Purpose: Self-checking bench of the startup sequencer.
// Assumes: Registers answer after the request is taken; outputs settle between edges.
// Notes: Startup phases are read back from the status word, one edge per step.
`timescale 1ns/1ns
`include "css_consts.svh"
module css_sequencer_tb
  import css_pkg::*;
;
  logic clk_sys, sys_rst, wb_cyc, wb_stb, wb_we, wb_ack_o, run, hold_low, lock;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat, wb_dat_o, rd;
  logic [1:0] sel, policy;
  logic [5:0] rate;
  logic cfg_clk, user_clk, scan_clk, fin_i, fin_o, fin_oe_n, bmem_en, cm_rst, cm_seen;
  css_glob_type glob;
  int miscompares, tests_run, cycles;
  logic [31:0] crc_exp;

  css_sequencer dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cfg_clk_in(cfg_clk),
    .user_clk_in(user_clk), .scan_clk_in(scan_clk), .finish_pin_i(fin_i),
    .clock_lock_i(lock), .finish_pin_o(fin_o), .finish_pin_oe_n(fin_oe_n), .glob_o(glob),
    .block_memory_en_o(bmem_en), .clock_manager_rst_o(cm_rst),
    .config_clock_rate_o(rate), .impedance_update_policy_o(policy));
  css_far_model far (.run(run), .sel(sel), .hold_low(hold_low), .finish_pin_o(fin_o),
    .finish_pin_oe_n(fin_oe_n), .cfg_clk_in(cfg_clk), .user_clk_in(user_clk),
    .scan_clk_in(scan_clk), .finish_pin_i(fin_i));

  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic tally_and_finish();
    $display("Counts: %0d checks, %0d mismatches", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // The limit is far above the roughly one thousand cycles the tests take.
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cm_rst === 1'b1)
      cm_seen <= 1'b1;
    if (cycles == 6000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
    @(posedge clk_sys);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat <= d;
    wb_sel <= 4'hf;
    do
    begin
      @(posedge clk_sys);
    end
    while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic step(input int n);
    repeat (n)
    begin
      run <= 1'b1;
      repeat (8) @(posedge clk_sys);
      run <= 1'b0;
      repeat (8) @(posedge clk_sys);
    end
  endtask

  task automatic t_regs();
    do_reset();
    wb(1'b0, `CSS_OFF_CTRL, 32'h0);
    check(rd, `CSS_RST_CTRL);
    check(rate, 6'h04);
    wb(1'b0, `CSS_OFF_PHASE, 32'h0);
    check(rd, `CSS_RST_PHASE);
    check(glob, 4'hb);
    check(bmem_en, 1'b0);
    check(fin_oe_n, 1'b1);
    wb(1'b1, 8'h3c, 32'hffffffff);
    wb(1'b0, 8'h3c, 32'h0);
    check(rd, 32'h0);
    cm_seen <= 1'b0;
    wb(1'b1, `CSS_OFF_CTRL, 32'h00000014);
    wb(1'b1, `CSS_OFF_CMD, 32'h0000000c);
    repeat (3) @(posedge clk_sys);
    check(cm_seen, 1'b1);
    wb(1'b1, `CSS_OFF_CTRL, 32'h00000004);
    cm_seen <= 1'b0;
    wb(1'b1, `CSS_OFF_CMD, 32'h0000000c);
    repeat (3) @(posedge clk_sys);
    check(cm_seen, 1'b0);
    wb(1'b1, `CSS_OFF_CTRL, 32'h0000000c);
    wb(1'b1, `CSS_OFF_DATA, 32'h00c0ffee);
    check(glob.global_high_hold, 1'b0);
    check(glob.global_set_reset, 1'b0);
    $display("test regs done");
  endtask

  task automatic t_startup();
    logic [2:0] q;
    do_reset();
    wb(1'b1, `CSS_OFF_CTRL, 32'h00008520);
    check(rate, 6'h05);
    check(policy, 2'h2);
    wb(1'b1, `CSS_OFF_PHASE, 32'h00075664);
    wb(1'b1, `CSS_OFF_CRCREF, 32'h0000ffff);
    wb(1'b1, `CSS_OFF_DATA, 32'h12345678);
    wb(1'b1, `CSS_OFF_CMD, 32'h00000001);
    for (int i = 0; i < 12; i++)
    begin
      wb(1'b0, `CSS_OFF_STATUS, 32'h0);
      q = (rd[4:3] == 2'h2) ? 3'h7 : rd[2:0];
      check(fin_o, q >= 3'h4);
      check(fin_oe_n, q < 3'h4);
      check(glob.global_tristate, q < 3'h5);
      check(glob.global_set_reset, q < 3'h6);
      check(glob.global_write_enable, q >= 3'h6);
      check(bmem_en, q >= 3'h6);
      if (rd[4:3] == 2'h2)
        break;
      step(1);
    end
    check(rd[4:3], 2'h2);
    $display("test startup done");
  endtask

  task automatic t_hold();
    do_reset();
    lock <= 1'b0;
    hold_low <= 1'b1;
    sel <= 2'h1;
    wb(1'b1, `CSS_OFF_CTRL, 32'h00000040);
    wb(1'b1, `CSS_OFF_PHASE, 32'h00020701);
    wb(1'b1, `CSS_OFF_CMD, 32'h00000001);
    step(6);
    wb(1'b0, `CSS_OFF_STATUS, 32'h0);
    check(rd[2:0], 3'h2);
    check(fin_o, 1'b1);
    check(glob.global_tristate, 1'b1);
    lock <= 1'b1;
    step(6);
    check(glob.global_write_enable, 1'b0);
    check(bmem_en, 1'b0);
    check(glob.global_set_reset, 1'b1);
    hold_low <= 1'b0;
    step(2);
    check(glob.global_set_reset, 1'b0);
    check(glob.global_tristate, 1'b0);
    check(glob.global_write_enable, 1'b0);
    $display("test hold done");
  endtask

  task automatic t_crc();
    do_reset();
    wb(1'b1, `CSS_OFF_CTRL, 32'h00000004);
    wb(1'b1, `CSS_OFF_CRCREF, 32'h0);
    wb(1'b1, `CSS_OFF_DATA, 32'h5a5a5a5a);
    wb(1'b1, `CSS_OFF_CMD, 32'h00000001);
    repeat (4) @(posedge clk_sys);
    wb(1'b0, `CSS_OFF_STATUS, 32'h0);
    check(rd[7], 1'b1);
    check(rd[4:3], 2'h0);
    $display("test crc done");
  endtask

  // Pipelined finish on the scan clock: the sampled finish lags the pin by one startup edge.
  task automatic t_pipe();
    do_reset();
    hold_low <= 1'b1;
    sel <= 2'h2;
    wb(1'b1, `CSS_OFF_CTRL, 32'h00000081);
    wb(1'b1, `CSS_OFF_PHASE, 32'h00070002);
    wb(1'b1, `CSS_OFF_CMD, 32'h00000001);
    step(4);
    wb(1'b0, `CSS_OFF_STATUS, 32'h0);
    check(rd[2:0], 3'h2);
    check(fin_o, 1'b1);
    hold_low <= 1'b0;
    repeat (8) @(posedge clk_sys);
    check(glob.global_set_reset, 1'b1);
    step(1);
    wb(1'b0, `CSS_OFF_STATUS, 32'h0);
    check(rd[2:0], 3'h2);
    check(glob.global_set_reset, 1'b0);
    step(1);
    wb(1'b0, `CSS_OFF_STATUS, 32'h0);
    check(rd[2:0], 3'h3);
    $display("test pipe done");
  endtask

  // Reference checksum, bit-serial with the most significant data bit first.
  function automatic logic [31:0] crc_model(input logic [31:0] crc, input logic [31:0] d);
    logic [31:0] c;
    logic fb;
    c = crc;
    for (int i = 31; i >= 0; i--)
    begin
      fb = c[31] ^ d[i];
      c = c << 1;
      if (fb)
        c = c ^ `CSS_CRC_POLY;
    end
    return c;
  endfunction

  task automatic send(input logic [31:0] d);
    wb(1'b1, `CSS_OFF_DATA, d);
    crc_exp = crc_model(crc_exp, d);
  endtask

  // A debug-style stream with a repeated frame; the good checksum must let startup run.
  task automatic t_stream();
    do_reset();
    sel <= 2'h0;
    crc_exp = `CSS_CRC_INIT;
    wb(1'b1, `CSS_OFF_PHASE, 32'h00075674);
    send(32'h0f0f1234);
    send(32'h00000000);
    send(32'h00000100);
    send(32'hcafe0001);
    send(32'h00000101);
    send(32'hcafe0001);
    wb(1'b0, `CSS_OFF_STATUS, 32'h0);
    check(rd[31:16], crc_exp[15:0]);
    wb(1'b1, `CSS_OFF_CRCREF, crc_exp);
    wb(1'b1, `CSS_OFF_CMD, 32'h00000001);
    wb(1'b0, `CSS_OFF_STATUS, 32'h0);
    check(rd[7:3], 5'h01);
    step(9);
    check(glob.global_set_reset, 1'b1);
    check(glob.global_write_enable, 1'b1);
    check(glob.global_tristate, 1'b0);
    $display("test stream done");
  endtask

  initial
  begin
    sys_rst = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'h0;
    wb_dat = 32'h0;
    run = 1'b0;
    sel = 2'h0;
    hold_low = 1'b0;
    lock = 1'b1;
    cm_seen = 1'b0;
    miscompares = 0;
    tests_run = 0;
    cycles = 0;
    t_regs();
    t_startup();
    t_hold();
    t_crc();
    t_pipe();
    t_stream();
    tally_and_finish();
  end
endmodule
